// File: rtl/raux_regs.v
/*
 * Radio auxiliary control register bank behind an AHB-Lite slave port.
 * Holds strength readback, the frequency correction limit, calibration
 * source settings, shutdown request, power enables, converter readback
 * and the battery alarm threshold and flag.
 * Assumes a single AHB-Lite master, word transfers only, and status
 * inputs that are synchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "raux_consts.vh"

module raux_regs #(
	parameter AFC_W = 9
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire packet_received,
	input wire [7:0] signal_strength_value,
	input wire receive_state_entry,
	input wire [8:0] if_bandwidth_khz,
	input wire signed [AFC_W-1:0] afc_raw,
	input wire chip_select,
	input wire adc_result_valid,
	input wire [7:0] adc_result,
	input wire [11:0] battery_mv,
	output reg signed [8:0] signal_strength_dbm,
	output reg strength_valid,
	output wire [7:0] pull_in_limit,
	output reg signed [AFC_W-1:0] afc_limited,
	output wire image_cal_override_enable,
	output wire cal_source_enable,
	output wire [4:0] cal_source_divide,
	output wire cal_power_enable,
	output wire [2:0] cal_power_multiple,
	output wire shutdown_start,
	output wire converter_path_enable,
	output wire strength_circuit_enable,
	output wire if_filter_enable,
	output wire mixer_enable,
	output wire front_amp_enable,
	output wire temperature_monitor_enable,
	output wire battery_monitor_enable,
	output wire battery_below_trip,
	output wire battery_alarm_flag
);

	// ***********************************************************
	// Functions
	// ***********************************************************

	// Clamps a signed correction to plus or minus the limit.
	function signed [AFC_W-1:0] clamp_afc;
		input signed [AFC_W-1:0] raw;
		input [7:0] lim;
		reg signed [AFC_W+1:0] wide;
		reg signed [AFC_W+1:0] slim;
		begin
			wide = raw;
			slim = $signed({{(AFC_W-6){1'b0}}, lim});
			if (wide > slim) begin
				clamp_afc = slim[AFC_W-1:0];
			end else if (wide < -slim) begin
				clamp_afc = -slim[AFC_W-1:0];
			end else begin
				clamp_afc = raw;
			end
		end
	endfunction

	// Maps the calibration power code to a multiple of minimum level.
	function [2:0] power_multiple;
		input [2:0] code;
		begin
			case (code)
				3'h0: power_multiple = 3'h0;
				3'h1, 3'h2: power_multiple = 3'h1;
				3'h3, 3'h4: power_multiple = 3'h2;
				3'h5, 3'h6: power_multiple = 3'h3;
				default: power_multiple = 3'h4;
			endcase
		end
	endfunction

	// ***********************************************************
	// Bus state
	// ***********************************************************

	// Data phase states, one-hot.
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_WR = 4'b0010;
	localparam [3:0] ST_RD1 = 4'b0100;
	localparam [3:0] ST_RD2 = 4'b1000;

	reg [3:0] state_r; // Current data phase.
	reg [3:0] state_nxt; // Next data phase.
	reg [`RAUX_IDX_W-1:0] idx_r; // Register index latched from the address phase.
	wire accept; // An address phase is taken this edge.
	wire [`RAUX_IDX_W-1:0] idx_in; // Index presented in the address phase.
	wire wr_en; // Write data phase strobe.
	reg [7:0] rd_mux; // Read data of the latched index.

	// ***********************************************************
	// Register storage
	// ***********************************************************

	reg [7:0] strength_r; // Stored strength value.
	reg [7:0] limit_r; // Correction pull-in limit.
	reg [5:0] cal_cfg_r; // Calibration configuration bits 5:0.
	reg shutdown_r; // Shutdown request bit.
	reg [4:0] rx_en_r; // Receive chain enables.
	reg [1:0] aux_en_r; // Monitor enables.
	reg [7:0] conv_r; // Last converter result.
	reg [4:0] trip_code_r; // Battery trip code.
	reg alarm_flag_r; // Sticky battery alarm.
	wire alarm_pulse; // Crossing event from the comparator.

	// ***********************************************************
	// Address phase and data phase tracking
	// ***********************************************************

	assign accept = hsel & htrans[1] & hready;
	assign idx_in = haddr[11:2];
	assign wr_en = state_r[1];
	// Reads wait one cycle so hrdata comes from a flop and still sees
	// a write made in the directly preceding data phase.
	assign hreadyout = ~state_r[2];
	assign hresp = 1'b0;

	// Next data phase follows the accepted transfer, if any.
	always @* begin
		case (state_r)
			ST_RD1: begin
				state_nxt = ST_RD2;
			end
			default: begin
				if (accept) begin
					state_nxt = hwrite ? ST_WR : ST_RD1;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// State and index latch; the index is only caught while ready is high.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			idx_r <= {`RAUX_IDX_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (accept && !state_r[2]) begin
				idx_r <= idx_in;
			end
		end
	end

	// ***********************************************************
	// Read path
	// ***********************************************************

	// Read decode; unmapped and reserved bits read as zero.
	always @* begin
		case (idx_r)
			`RAUX_IDX_STRENGTH: rd_mux = strength_r;
			`RAUX_IDX_PULL_IN: rd_mux = limit_r;
			`RAUX_IDX_CAL_CFG: rd_mux = {2'b00, cal_cfg_r};
			`RAUX_IDX_SHUTDOWN: rd_mux = {7'h00, shutdown_r};
			`RAUX_IDX_RX_EN: rd_mux = {3'h0, rx_en_r};
			`RAUX_IDX_AUX_EN: rd_mux = {6'h00, aux_en_r};
			`RAUX_IDX_CONV_HIGH: rd_mux = {2'b00, conv_r[7:2]};
			`RAUX_IDX_CONV_LOW: rd_mux = {conv_r[1:0], 6'h00};
			`RAUX_IDX_BATT_TRIP: rd_mux = {3'h0, trip_code_r};
			`RAUX_IDX_IRQ_SRC1: rd_mux = {alarm_flag_r, 7'h00};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data is registered in the wait cycle and held afterwards.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (state_r[2]) begin
			hrdata <= {24'h000000, rd_mux};
		end
	end

	// ***********************************************************
	// Software written registers
	// ***********************************************************

	// Plain control registers; unmapped writes are dropped.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_cfg_r <= `RAUX_RST_CAL_CFG;
			shutdown_r <= 1'b0;
			rx_en_r <= `RAUX_RST_RX_EN;
			aux_en_r <= `RAUX_RST_AUX_EN;
			trip_code_r <= `RAUX_RST_BATT_TRIP;
		end else if (wr_en) begin
			case (idx_r)
				`RAUX_IDX_CAL_CFG: cal_cfg_r <= hwdata[5:0];
				`RAUX_IDX_SHUTDOWN: shutdown_r <= hwdata[0];
				`RAUX_IDX_RX_EN: rx_en_r <= hwdata[4:0];
				`RAUX_IDX_AUX_EN: aux_en_r <= hwdata[1:0];
				`RAUX_IDX_BATT_TRIP: trip_code_r <= hwdata[4:0];
				default: begin
				end
			endcase
		end
	end

	// Pull-in limit: software may write it, but entry to the receive
	// state reloads it and wins a same-cycle collision, as the internal
	// processor would overwrite any earlier value.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit_r <= `RAUX_RST_PULL_IN;
		end else if (receive_state_entry) begin
			limit_r <= if_bandwidth_khz[8:1];
		end else if (wr_en && idx_r == `RAUX_IDX_PULL_IN) begin
			limit_r <= hwdata[7:0];
		end
	end

	// ***********************************************************
	// Hardware captured readbacks
	// ***********************************************************

	// Strength is caught at each packet; dBm form is offset by 107.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strength_r <= `RAUX_RST_STRENGTH;
			strength_valid <= 1'b0;
			signal_strength_dbm <= 9'sh000;
		end else if (packet_received) begin
			strength_r <= signal_strength_value;
			strength_valid <= 1'b1;
			signal_strength_dbm <= $signed({1'b0, signal_strength_value} - `RAUX_DBM_OFFSET);
		end
	end

	// Converter result, kept whole and split only on read.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_r <= `RAUX_RST_CONV;
		end else if (adc_result_valid) begin
			conv_r <= adc_result;
		end
	end

	// ***********************************************************
	// Battery alarm
	// ***********************************************************

	raux_batt_mon u_batt (
		.hclk(hclk),
		.hresetn(hresetn),
		.monitor_enable(aux_en_r[`RAUX_AUX_BATT_BIT]),
		.battery_trip_code(trip_code_r),
		.battery_mv(battery_mv),
		.below_trip_r(battery_below_trip),
		.alarm_pulse_r(alarm_pulse)
	);

	// Sticky alarm flag, cleared by writing one to bit 7; a new alarm in
	// the clearing cycle wins so that no crossing is lost.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_flag_r <= 1'b0;
		end else if (alarm_pulse) begin
			alarm_flag_r <= 1'b1;
		end else if (wr_en && idx_r == `RAUX_IDX_IRQ_SRC1 && hwdata[`RAUX_IRQ_BATT_BIT]) begin
			alarm_flag_r <= 1'b0;
		end
	end

	assign battery_alarm_flag = alarm_flag_r;

	// ***********************************************************
	// Frequency correction bound
	// ***********************************************************

	// Registered clamp of the raw correction to the pull-in limit.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			afc_limited <= {AFC_W{1'b0}};
		end else begin
			afc_limited <= clamp_afc(afc_raw, limit_r);
		end
	end

	assign pull_in_limit = limit_r;

	// ***********************************************************
	// Decoded control outputs
	// ***********************************************************

	assign image_cal_override_enable = cal_cfg_r[`RAUX_CAL_OVR_BIT];
	assign cal_source_enable = |cal_cfg_r[`RAUX_CAL_FREQ_HI:`RAUX_CAL_FREQ_LO];
	// Divide ratio 4, 8 or 16 as a shift of two; zero when disabled.
	assign cal_source_divide = cal_source_enable ?
		(5'h02 << cal_cfg_r[`RAUX_CAL_FREQ_HI:`RAUX_CAL_FREQ_LO]) : 5'h00;
	assign cal_power_multiple = power_multiple(cal_cfg_r[`RAUX_CAL_PWR_HI:`RAUX_CAL_PWR_LO]);
	assign cal_power_enable = |cal_cfg_r[`RAUX_CAL_PWR_HI:`RAUX_CAL_PWR_LO];

	// Shutdown needs both the request and the host's select level.
	assign shutdown_start = shutdown_r & chip_select;

	assign converter_path_enable = rx_en_r[`RAUX_RX_CONV_BIT];
	assign strength_circuit_enable = rx_en_r[`RAUX_RX_STRENGTH_BIT];
	assign if_filter_enable = rx_en_r[`RAUX_RX_FILTER_BIT];
	assign mixer_enable = rx_en_r[`RAUX_RX_MIXER_BIT];
	assign front_amp_enable = rx_en_r[`RAUX_RX_AMP_BIT];
	assign temperature_monitor_enable = aux_en_r[`RAUX_AUX_TEMP_BIT];
	assign battery_monitor_enable = aux_en_r[`RAUX_AUX_BATT_BIT];

endmodule
`default_nettype wire

// File: shared/raux_consts.vh
/*
 * Constants for the radio auxiliary control register bank: register
 * indices, field positions, reset values and conversion figures.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef RAUX_CONSTS_VH
`define RAUX_CONSTS_VH

// ***********************************************************
// Register indices (byte address is four times the index)
// ***********************************************************
`define RAUX_IDX_W 10
`define RAUX_IDX_STRENGTH 10'h312
`define RAUX_IDX_PULL_IN 10'h315
`define RAUX_IDX_CAL_CFG 10'h319
`define RAUX_IDX_SHUTDOWN 10'h322
`define RAUX_IDX_RX_EN 10'h324
`define RAUX_IDX_AUX_EN 10'h325
`define RAUX_IDX_CONV_HIGH 10'h327
`define RAUX_IDX_CONV_LOW 10'h328
`define RAUX_IDX_BATT_TRIP 10'h32d
`define RAUX_IDX_IRQ_SRC1 10'h337

// ***********************************************************
// Reset values
// ***********************************************************
`define RAUX_RST_STRENGTH 8'h00
`define RAUX_RST_PULL_IN 8'h32
`define RAUX_RST_CAL_CFG 6'h00
`define RAUX_RST_RX_EN 5'h00
`define RAUX_RST_AUX_EN 2'h0
`define RAUX_RST_CONV 8'h00
`define RAUX_RST_BATT_TRIP 5'h00

// ***********************************************************
// Field positions
// ***********************************************************
`define RAUX_CAL_OVR_BIT 5
`define RAUX_CAL_FREQ_HI 4
`define RAUX_CAL_FREQ_LO 3
`define RAUX_CAL_PWR_HI 2
`define RAUX_CAL_PWR_LO 0
`define RAUX_RX_CONV_BIT 4
`define RAUX_RX_STRENGTH_BIT 3
`define RAUX_RX_FILTER_BIT 2
`define RAUX_RX_MIXER_BIT 1
`define RAUX_RX_AMP_BIT 0
`define RAUX_AUX_TEMP_BIT 1
`define RAUX_AUX_BATT_BIT 0
`define RAUX_IRQ_BATT_BIT 7

// ***********************************************************
// Conversion figures
// ***********************************************************
`define RAUX_DBM_OFFSET 9'd107
`define RAUX_TRIP_BASE_MV 12'd1700
`define RAUX_TRIP_STEP_MV 12'd62

`endif

// File: rtl/raux_batt_mon.v
/*
 * Battery alarm comparator: turns the trip code into a trip voltage and
 * flags a fall of the battery level below it.
 * Assumes battery_mv is a settled millivolt reading synchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "raux_consts.vh"

module raux_batt_mon (
	input wire hclk,
	input wire hresetn,
	input wire monitor_enable,
	input wire [4:0] battery_trip_code,
	input wire [11:0] battery_mv,
	output reg below_trip_r,
	output reg alarm_pulse_r
);

	// ***********************************************************
	// Trip voltage
	// ***********************************************************

	// Trip in millivolts; the largest code gives 3622 mV, so 12 bits suffice.
	wire [11:0] trip_mv;
	wire below_nxt;

	assign trip_mv = `RAUX_TRIP_BASE_MV + `RAUX_TRIP_STEP_MV * {7'h00, battery_trip_code};
	assign below_nxt = monitor_enable & (battery_mv < trip_mv);

	// ***********************************************************
	// Crossing detector
	// ***********************************************************

	// A disabled monitor reads as not below, so enabling it on a flat
	// battery still raises one alarm.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			below_trip_r <= 1'b0;
			alarm_pulse_r <= 1'b0;
		end else begin
			below_trip_r <= below_nxt;
			alarm_pulse_r <= below_nxt & ~below_trip_r;
		end
	end

endmodule
`default_nettype wire

// File: verif/raux_regs_chk.sv
/* Checker for raux_regs: event capture, field decode, shutdown gating
 * and battery alarm relations.
 * Assumes it is bound onto raux_regs, whose port names it shares. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Checker
// ****************
module raux_regs_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic packet_received,
	input wire logic [7:0] signal_strength_value,
	input wire logic receive_state_entry,
	input wire logic [8:0] if_bandwidth_khz,
	input wire logic chip_select,
	input wire logic signed [8:0] signal_strength_dbm,
	input wire logic strength_valid,
	input wire logic [7:0] pull_in_limit,
	input wire logic cal_source_enable,
	input wire logic [4:0] cal_source_divide,
	input wire logic cal_power_enable,
	input wire logic [2:0] cal_power_multiple,
	input wire logic shutdown_start,
	input wire logic battery_monitor_enable,
	input wire logic battery_below_trip,
	input wire logic battery_alarm_flag
);
	// One clock domain, so reset disables every relation at once.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A shutdown must never start while the select line is low.
	AST_SHUT: assert property (shutdown_start |-> chip_select)
		else $error("shutdown started without select");
	AST_DBM: assert property (packet_received |=>
		signal_strength_dbm == $signed({1'b0, $past(signal_strength_value)}) - 9'sd107)
		else $error("strength in dBm wrong after capture");
	AST_VALID: assert property (packet_received |=> strength_valid [*2])
		else $error("strength valid not held");
	// The limit is half the bandwidth, so compare one bit wider.
	AST_LOAD: assert property (receive_state_entry |=>
		{1'b0, pull_in_limit} == ($past(if_bandwidth_khz) >> 1))
		else $error("pull-in limit not half bandwidth");
	AST_DIV: assert property (cal_source_enable == (cal_source_divide != 5'h00) &&
		cal_source_divide inside {5'h00, 5'h04, 5'h08, 5'h10})
		else $error("calibration divider decode wrong");
	AST_PWR: assert property (cal_power_enable == (cal_power_multiple != 3'h0) &&
		cal_power_multiple <= 3'h4)
		else $error("calibration power decode wrong");
	AST_BELOW: assert property (!$past(battery_monitor_enable) |-> !battery_below_trip)
		else $error("below trip with monitor off");
	AST_ALARM: assert property ($rose(battery_below_trip) |=> battery_alarm_flag)
		else $error("alarm flag not set on crossing");
	COV_PKT: cover property (packet_received);
	COV_ALM: cover property ($rose(battery_alarm_flag));
	COV_SHUT: cover property (shutdown_start);
endmodule
bind raux_regs raux_regs_chk u_chk (.*);
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for raux_regs, driven over AHB-Lite.
 * Assumes raux_consts.vh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "raux_consts.vh"
module tb;
	// ****************
	// Stimulus and observed signals
	// ****************
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, chip_select = 0;
	logic packet_received = 0, receive_state_entry = 0, adc_result_valid = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [11:0] haddr = 0, battery_mv = 12'hfff;
	logic [31:0] hwdata = 0, rdv;
	logic [7:0] signal_strength_value = 0, adc_result = 0;
	logic [8:0] if_bandwidth_khz = 0, e9;
	logic signed [8:0] afc_raw = 0;
	logic [7:0] sv[3] = '{8'h2a, 8'h00, 8'hff};
	logic [8:0] ar[3] = '{9'h096, 9'h16a, 9'h032}, ae[3] = '{9'h064, 9'h19c, 9'h032};
	wire hreadyout, hresp, strength_valid, image_cal_override_enable, cal_source_enable;
	wire cal_power_enable, shutdown_start, converter_path_enable, strength_circuit_enable;
	wire if_filter_enable, mixer_enable, front_amp_enable, temperature_monitor_enable;
	wire battery_monitor_enable, battery_below_trip, battery_alarm_flag;
	wire [31:0] hrdata;
	wire signed [8:0] signal_strength_dbm, afc_limited;
	wire [7:0] pull_in_limit;
	wire [4:0] cal_source_divide;
	wire [2:0] cal_power_multiple;
	wire [4:0] rx_en = {converter_path_enable, strength_circuit_enable, if_filter_enable,
		mixer_enable, front_amp_enable};
	int mismatches = 0, checks_done = 0;
	// The single slave's ready is the bus ready.
	raux_regs #(.AFC_W(9)) u_dut (.hready(hreadyout), .*);
	// 200 MHz clock.
	always #2.5 hclk = ~hclk;
	// ****************
	// Tasks
	// ****************
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One single transfer; each phase is held until ready is seen high.
	task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	// A write lands at its data-phase edge, so one more edge before looking.
	task automatic w(input logic [9:0] i, input logic [31:0] d);
		xfer(1, i, d);
		@(posedge hclk);
	endtask
	task automatic rc(input logic [9:0] i, input logic [31:0] e);
		xfer(0, i, 32'h0);
		cmp(rdv, e);
		cmp(hresp, 32'h0);
	endtask
	// One-cycle event strobe: 0 packet, 1 receive entry, 2 converter result.
	task automatic pulse(input int k);
		packet_received <= (k == 0);
		receive_state_entry <= (k == 1);
		adc_result_valid <= (k == 2);
		@(posedge hclk);
		packet_received <= 0;
		receive_state_entry <= 0;
		adc_result_valid <= 0;
		@(posedge hclk);
	endtask
	// Below-trip lags the reading by one edge and the flag by two.
	task automatic batt(input logic [11:0] mv, input logic e);
		battery_mv <= mv;
		repeat (3) @(posedge hclk);
		cmp(battery_below_trip, e);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		cmp(strength_valid, 32'h0);
		rc(`RAUX_IDX_STRENGTH, 32'h0);
		rc(`RAUX_IDX_PULL_IN, 32'h32);
		rc(`RAUX_IDX_CAL_CFG, 32'h0);
		rc(`RAUX_IDX_SHUTDOWN, 32'h0);
		rc(`RAUX_IDX_RX_EN, 32'h0);
		rc(`RAUX_IDX_AUX_EN, 32'h0);
		rc(`RAUX_IDX_CONV_LOW, 32'h0);
		rc(`RAUX_IDX_BATT_TRIP, 32'h0);
		rc(`RAUX_IDX_IRQ_SRC1, 32'h0);
		// Unmapped place: write dropped, reads zero.
		w(10'h3ff, 32'hff);
		rc(10'h3ff, 32'h0);
		// Every frequency and power code; reserved bits written high.
		for (int f = 0; f < 4; f++) begin
			for (int p = 0; p < 8; p++) begin
				w(`RAUX_IDX_CAL_CFG, {24'h0, 2'h3, f[0], f[1:0], p[2:0]});
				cmp(cal_source_divide, f == 0 ? 32'h0 : f == 1 ? 32'h4 : f == 2 ? 32'h8 : 32'h10);
				cmp(cal_source_enable, f != 0);
				cmp(cal_power_multiple, (p + 1) / 2);
				cmp(cal_power_enable, p != 0);
				cmp(image_cal_override_enable, f[0]);
				rc(`RAUX_IDX_CAL_CFG, {26'h0, f[0], f[1:0], p[2:0]});
			end
		end
		for (int b = 0; b < 5; b++) begin
			w(`RAUX_IDX_RX_EN, 32'he0 | (32'h1 << b));
			cmp(rx_en, 32'h1 << b);
			rc(`RAUX_IDX_RX_EN, 32'h1 << b);
		end
		for (int b = 0; b < 4; b++) begin
			w(`RAUX_IDX_AUX_EN, b);
			cmp({temperature_monitor_enable, battery_monitor_enable}, b);
		end
		w(`RAUX_IDX_SHUTDOWN, 32'h1);
		cmp(shutdown_start, 32'h0);
		chip_select <= 1;
		@(posedge hclk);
		cmp(shutdown_start, 32'h1);
		w(`RAUX_IDX_SHUTDOWN, 32'h0);
		cmp(shutdown_start, 32'h0);
		// Strength capture, including both ends of the code range.
		for (int k = 0; k < 3; k++) begin
			signal_strength_value <= sv[k];
			pulse(0);
			e9 = {1'b0, sv[k]} - 9'd107;
			cmp({signal_strength_dbm}, e9);
			cmp(strength_valid, 32'h1);
			rc(`RAUX_IDX_STRENGTH, sv[k]);
		end
		if_bandwidth_khz <= 9'd200;
		pulse(1);
		rc(`RAUX_IDX_PULL_IN, 32'h64);
		cmp(pull_in_limit, 32'h64);
		for (int k = 0; k < 3; k++) begin
			afc_raw <= ar[k];
			repeat (2) @(posedge hclk);
			cmp({afc_limited}, ae[k]);
		end
		w(`RAUX_IDX_PULL_IN, 32'h1e);
		rc(`RAUX_IDX_PULL_IN, 32'h1e);
		adc_result <= 8'hb7;
		pulse(2);
		rc(`RAUX_IDX_CONV_HIGH, 32'h2d);
		rc(`RAUX_IDX_CONV_LOW, 32'hc0);
		// Trip code 5 puts the level at 2010 mV.
		w(`RAUX_IDX_BATT_TRIP, 32'he5);
		rc(`RAUX_IDX_BATT_TRIP, 32'h05);
		w(`RAUX_IDX_AUX_EN, 32'h1);
		batt(12'd2010, 0);
		batt(12'd2009, 1);
		cmp(battery_alarm_flag, 32'h1);
		rc(`RAUX_IDX_IRQ_SRC1, 32'h80);
		batt(12'd3000, 0);
		w(`RAUX_IDX_IRQ_SRC1, 32'h80);
		rc(`RAUX_IDX_IRQ_SRC1, 32'h0);
		// Top code puts the level at 3622 mV.
		w(`RAUX_IDX_BATT_TRIP, 32'h1f);
		batt(12'd3621, 1);
		batt(12'd3622, 0);
		rc(`RAUX_IDX_IRQ_SRC1, 32'h80);
		w(`RAUX_IDX_AUX_EN, 32'h0);
		batt(12'd1000, 0);
		// Reset in mid-run: written and captured state returns to reset values.
		hresetn <= 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		cmp(strength_valid, 32'h0);
		cmp(pull_in_limit, 32'h32);
		rc(`RAUX_IDX_STRENGTH, 32'h0);
		rc(`RAUX_IDX_IRQ_SRC1, 32'h0);
		rc(`RAUX_IDX_BATT_TRIP, 32'h0);
		end_of_test;
	end
	// Hang guard, far beyond the few hundred cycles the run needs.
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
endmodule
`default_nettype wire
